// ===== verilog/pfa_pkg.sv
// constants, state types and command codes of the fast programming port
// assumes a single 20 MHz clock and synchronous pin inputs
//
// Overview of operation
// RULE1 - set-bits command sets masked general bits
// RULE2 - clear-bits command clears bits whose pattern is 1
// RULE3 - full erase also clears general bits
// RULE4 - set/clear: command write, then data write
// RULE5 - read-bits: command write, then read returns mask
// RULE6 - security bit locks the port completely
// RULE7 - programmer selects controller 0 before securing
// RULE8 - only long erase pin press clears security
// RULE9 - commands act on current controller, default zero
// RULE10 - select command: data 0 or 1 picks controller
// RULE11 - memory write: command, two addresses, data words
// RULE12 - address increments after each data write
// RULE13 - get-version data phase returns interface version
// RULE14 - new command entry flushes the previous one
// RULE15 - write handshake: latch, drop ready, wait strobe
// RULE16 - read handshake: drive data, valid low, release
// RULE17 - command and mode codes are design parameters
// RULE18 - general, security, select state persist
package pfa_pkg;
	localparam int MODE_W = 4;
	localparam int DATA_W = 16;
	localparam int ADDR_W = 32;
	localparam int GP_W = 16;
	localparam int AV_ADDR_W = 5;

	// codes shared with the programmer model
	localparam logic [MODE_W-1:0] MODE_COMMAND_ENTRY = 4'h1; // RULE17
	localparam logic [MODE_W-1:0] MODE_LOW_ADDRESS = 4'h2;
	localparam logic [MODE_W-1:0] MODE_HIGH_ADDRESS = 4'h3;
	localparam logic [MODE_W-1:0] MODE_DATA = 4'h4;

	localparam logic [DATA_W-1:0] CMD_FULL_ERASE = 16'h0010; // RULE17
	localparam logic [DATA_W-1:0] CMD_SET_GENERAL_BITS = 16'h0020;
	localparam logic [DATA_W-1:0] CMD_CLEAR_GENERAL_BITS = 16'h0021;
	localparam logic [DATA_W-1:0] CMD_READ_GENERAL_BITS = 16'h0022;
	localparam logic [DATA_W-1:0] CMD_SET_SECURITY = 16'h0030;
	localparam logic [DATA_W-1:0] CMD_SELECT_CONTROLLER = 16'h0040;
	localparam logic [DATA_W-1:0] CMD_MEMORY_WRITE = 16'h0050;
	localparam logic [DATA_W-1:0] CMD_GET_VERSION = 16'h0060;

	// arbitrary value
	localparam logic [DATA_W-1:0] IF_VERSION = 16'h0001;
	localparam logic [DATA_W-1:0] CTRL_MAX_SEL = 16'h0001;
	localparam logic [ADDR_W-1:0] ADDR_STEP = 32'h0000_0001;

	localparam logic [AV_ADDR_W-1:0] REG_CTRL = 5'h00;
	localparam logic [AV_ADDR_W-1:0] REG_STATUS = 5'h04;
	localparam logic [AV_ADDR_W-1:0] REG_GPBITS = 5'h08;
	localparam logic [AV_ADDR_W-1:0] REG_ADDR = 5'h0c;
	localparam logic [AV_ADDR_W-1:0] REG_VERSION = 5'h10;
	localparam int CTRL_PORT_EN_BIT = 0;
	localparam logic CTRL_PORT_EN_RST = 1'b1;
	localparam int STAT_SECURED_BIT = 0;
	localparam int STAT_CTRL_SEL_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	localparam int CLK_HZ = 20_000_000;
	localparam int ERASE_TIME_MS = 220;
	localparam int ERASE_CYCLES_DEF = (CLK_HZ / 1000) * ERASE_TIME_MS;
	localparam int ERASE_CNT_W = 23;

	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_EXEC = 3'b001,
		HS_RD_WAIT = 3'b010,
		HS_RD_DRIVE = 3'b011,
		HS_WAIT_RELEASE = 3'b100,
		HS_LOCKED = 3'b101
	} pfa_hs_t;

	typedef struct packed {
		pfa_hs_t hs;
		logic [MODE_W-1:0] mode;
		logic [DATA_W-1:0] data;
		logic [DATA_W-1:0] cmd;
		logic [ADDR_W-1:0] addr;
		logic ctrlSel;
		logic secured;
		logic portEn;
		logic [DATA_W-1:0] dOut;
		logic dOe;
		logic memWr;
		logic [ADDR_W-1:0] memAddr;
		logic [DATA_W-1:0] memData;
		logic flush;
		logic eraseReq;
		logic eraseSel;
		logic avAck;
		logic [31:0] rdata;
	} pfa_state_t;

	typedef struct packed {
		logic [GP_W-1:0] bits;
	} pfa_bank_t;

	typedef struct packed {
		logic [ERASE_CNT_W-1:0] cnt;
		logic done;
		logic fire;
	} pfa_erase_t;
endpackage

// ===== verilog/pfa_gp_bank.sv
// general-purpose nonvolatile bits of one flash controller
// assumes at most one of set and clear per cycle from the sequencer; a wipe wins over both
`timescale 1ns/1ns
module pfa_gp_bank (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic setEn,
	input wire logic clrEn,
	input wire logic wipe,
	input wire logic [pfa_pkg::GP_W-1:0] pattern,
	output logic [pfa_pkg::GP_W-1:0] bits
);
	import pfa_pkg::*;

	pfa_bank_t st_ff;
	pfa_bank_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (wipe) begin
			nxt_st.bits = '0; // RULE3
		end else if (setEn) begin
			nxt_st.bits = st_ff.bits | pattern; // RULE1
		end else if (clrEn) begin
			nxt_st.bits = st_ff.bits & ~pattern; // RULE2
		end
	end

	// state held across commands, touched only by the strobes above
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0; // RULE18
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign bits = st_ff.bits;
endmodule

// ===== verilog/pfa_erase_timer.sv
// erase pin qualifier: one pulse after a long press with test low
// assumes the pin is already synchronous to mclk
`timescale 1ns/1ns
module pfa_erase_timer #(
	parameter int ERASE_CYCLES = pfa_pkg::ERASE_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic erasePin,
	input wire logic testSelectPin,
	output logic eraseFire
);
	import pfa_pkg::*;

	pfa_erase_t st_ff;
	pfa_erase_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.fire = 1'b0;
		// one shot per power-up; a release restarts the count
		if (!st_ff.done) begin
			if (erasePin && !testSelectPin) begin
				if (st_ff.cnt == ERASE_CNT_W'(ERASE_CYCLES)) begin
					nxt_st.fire = 1'b1; // RULE8
					nxt_st.done = 1'b1;
				end else begin
					nxt_st.cnt = st_ff.cnt + 1'b1;
				end
			end else begin
				nxt_st.cnt = '0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign eraseFire = st_ff.fire;
endmodule

// ===== verilog/pfa_seq.sv
// fast programming port sequencer with Avalon-MM status/control slave
// assumes programmer pins synchronous to mclk; flash array lives outside
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ns
module pfa_seq #(
	parameter int ERASE_CYCLES = pfa_pkg::ERASE_CYCLES_DEF
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [pfa_pkg::AV_ADDR_W-1:0] avAddress,
	input wire logic avRead,
	input wire logic avWrite,
	input wire logic [31:0] avWritedata,
	output logic [31:0] avReaddata,
	output logic avWaitrequest,
	input wire logic [pfa_pkg::MODE_W-1:0] modeIn,
	input wire logic [pfa_pkg::DATA_W-1:0] dataIn,
	output logic [pfa_pkg::DATA_W-1:0] dataOut,
	output logic dataOe,
	input wire logic commandStrobeN,
	input wire logic outputEnableN,
	output logic ready,
	output logic dataValidN,
	input wire logic erasePin,
	input wire logic testSelectPin,
	output logic memWrEn,
	output logic [pfa_pkg::ADDR_W-1:0] memWrAddr,
	output logic [pfa_pkg::DATA_W-1:0] memWrData,
	output logic flushReq,
	output logic fullEraseReq,
	output logic eraseCtrlSel,
	output logic currentCtrl,
	output logic securityActive
);
	import pfa_pkg::*;

	pfa_state_t st_ff;
	pfa_state_t nxt_st;
	logic [1:0][GP_W-1:0] gpBits;
	logic [1:0] bankSet;
	logic [1:0] bankClr;
	logic [1:0] bankWipe;
	logic eraseFire;
	logic execData;
	logic [GP_W-1:0] curBits;

	////////////////////////////////////////////////////////////////////////
	// one bank of general bits per flash controller

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_bank
			pfa_gp_bank u_bank (
				.mclk(mclk),
				.rst_n(rst_n),
				.setEn(bankSet[gi]),
				.clrEn(bankClr[gi]),
				.wipe(bankWipe[gi]),
				.pattern(st_ff.data),
				.bits(gpBits[gi])
			);
		end
	endgenerate

	pfa_erase_timer #(
		.ERASE_CYCLES(ERASE_CYCLES)
	) u_erase (
		.mclk(mclk),
		.rst_n(rst_n),
		.erasePin(erasePin),
		.testSelectPin(testSelectPin),
		.eraseFire(eraseFire)
	);

	assign curBits = gpBits[st_ff.ctrlSel];
	assign execData = (st_ff.hs == HS_EXEC) && (st_ff.mode == MODE_DATA);

	////////////////////////////////////////////////////////////////////////
	// bank strobes: set/clear/erase commands go to the current controller only; the pin erase wipes both banks

	always_comb begin
		bankSet = '0;
		bankClr = '0;
		bankWipe = '0;
		if (execData && st_ff.cmd == CMD_SET_GENERAL_BITS) begin
			bankSet[st_ff.ctrlSel] = 1'b1; // RULE1 RULE9
		end
		if (execData && st_ff.cmd == CMD_CLEAR_GENERAL_BITS) begin
			bankClr[st_ff.ctrlSel] = 1'b1; // RULE2 RULE9
		end
		if (execData && st_ff.cmd == CMD_FULL_ERASE) begin
			bankWipe[st_ff.ctrlSel] = 1'b1; // RULE3
		end
		// the pin erase wipes the general bits of both controllers; its full erase request names controller 0 only
		if (eraseFire) begin
			bankWipe = 2'b11; // RULE8
		end
	end

	////////////////////////////////////////////////////////////////////////
	// handshake and command sequencer

	always_comb begin
		nxt_st = st_ff;
		nxt_st.memWr = 1'b0;
		nxt_st.flush = 1'b0;
		nxt_st.eraseReq = 1'b0;
		unique case (st_ff.hs)
			HS_IDLE: begin
				if (!commandStrobeN && st_ff.portEn) begin
					nxt_st.mode = modeIn; // RULE15
					nxt_st.data = dataIn;
					nxt_st.hs = HS_EXEC;
				end
			end
			HS_EXEC: begin
				nxt_st.hs = HS_WAIT_RELEASE;
				if (st_ff.mode == MODE_COMMAND_ENTRY) begin
					// lets the flash side close a pending page buffer
					nxt_st.cmd = st_ff.data; // RULE4 RULE5 RULE13
					nxt_st.flush = 1'b1; // RULE14
				end else if (st_ff.mode == MODE_LOW_ADDRESS) begin
					nxt_st.addr[DATA_W-1:0] = st_ff.data; // RULE11 RULE12
				end else if (st_ff.mode == MODE_HIGH_ADDRESS) begin
					nxt_st.addr[ADDR_W-1:DATA_W] = st_ff.data; // RULE11 RULE12
				end else if (st_ff.mode == MODE_DATA) begin
					if (st_ff.cmd == CMD_FULL_ERASE) begin
						nxt_st.eraseReq = 1'b1; // RULE3 RULE9
						nxt_st.eraseSel = st_ff.ctrlSel;
					end else if (st_ff.cmd == CMD_SET_SECURITY) begin
						// security lives in controller 0 only
						if (!st_ff.ctrlSel) begin
							nxt_st.secured = 1'b1; // RULE7
						end
					end else if (st_ff.cmd == CMD_SELECT_CONTROLLER) begin
						if (st_ff.data <= CTRL_MAX_SEL) begin
							nxt_st.ctrlSel = st_ff.data[0]; // RULE10
						end
					end else if (st_ff.cmd == CMD_MEMORY_WRITE) begin
						nxt_st.memWr = 1'b1; // RULE11
						nxt_st.memAddr = st_ff.addr;
						nxt_st.memData = st_ff.data;
						nxt_st.addr = st_ff.addr + ADDR_STEP; // RULE12
					end else if (st_ff.cmd == CMD_READ_GENERAL_BITS || st_ff.cmd == CMD_GET_VERSION) begin
						nxt_st.hs = HS_RD_WAIT; // RULE5 RULE13
					end
				end
			end
			HS_RD_WAIT: begin
				if (!outputEnableN) begin
					nxt_st.dOut = (st_ff.cmd == CMD_GET_VERSION) ? IF_VERSION : curBits; // RULE5 RULE13
					nxt_st.dOe = 1'b1; // RULE16
					nxt_st.hs = HS_RD_DRIVE;
				end
			end
			HS_RD_DRIVE: begin
				if (outputEnableN) begin
					nxt_st.dOe = 1'b0; // RULE16
					nxt_st.hs = HS_WAIT_RELEASE;
				end
			end
			HS_WAIT_RELEASE: begin
				if (commandStrobeN) begin
					nxt_st.hs = st_ff.secured ? HS_LOCKED : HS_IDLE; // RULE15 RULE6
				end
			end
			HS_LOCKED: begin
				// no strobe is looked at until the pin erase
				if (!st_ff.secured) begin
					nxt_st.hs = HS_IDLE; // RULE6
				end
			end
			default: begin
				nxt_st.hs = HS_IDLE;
				nxt_st.dOe = 1'b0;
			end
		endcase

		// pin erase: clears security and everything behind it
		if (eraseFire) begin
			nxt_st.secured = 1'b0; // RULE8
			nxt_st.eraseReq = 1'b1;
			nxt_st.eraseSel = 1'b0;
		end

		// Avalon-MM: one wait state, write lands when waitrequest is low
		nxt_st.avAck = (avRead || avWrite) && !st_ff.avAck;
		if (avRead && !st_ff.avAck) begin
			nxt_st.rdata = '0;
			unique case (avAddress)
				REG_CTRL: nxt_st.rdata[CTRL_PORT_EN_BIT] = st_ff.portEn;
				REG_STATUS: begin
					nxt_st.rdata[STAT_SECURED_BIT] = st_ff.secured;
					nxt_st.rdata[STAT_CTRL_SEL_BIT] = st_ff.ctrlSel;
					nxt_st.rdata[STAT_BUSY_BIT] = (st_ff.hs != HS_IDLE);
				end
				REG_GPBITS: nxt_st.rdata = {gpBits[1], gpBits[0]};
				REG_ADDR: nxt_st.rdata = st_ff.addr;
				REG_VERSION: nxt_st.rdata[DATA_W-1:0] = IF_VERSION;
				default: nxt_st.rdata = '0;
			endcase
		end
		if (avWrite && st_ff.avAck && avAddress == REG_CTRL) begin
			nxt_st.portEn = avWritedata[CTRL_PORT_EN_BIT];
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_ff <= '0;
			st_ff.hs <= HS_IDLE;
			st_ff.ctrlSel <= 1'b0; // RULE9 RULE18
			st_ff.portEn <= CTRL_PORT_EN_RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	assign ready = (st_ff.hs == HS_IDLE);
	assign dataValidN = (st_ff.hs != HS_RD_DRIVE);
	assign dataOut = st_ff.dOut;
	assign dataOe = st_ff.dOe;
	assign memWrEn = st_ff.memWr;
	assign memWrAddr = st_ff.memAddr;
	assign memWrData = st_ff.memData;
	assign flushReq = st_ff.flush;
	assign fullEraseReq = st_ff.eraseReq;
	assign eraseCtrlSel = st_ff.eraseSel;
	assign currentCtrl = st_ff.ctrlSel;
	assign securityActive = st_ff.secured;
	assign avWaitrequest = (avRead || avWrite) && !st_ff.avAck;
	assign avReaddata = st_ff.rdata;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	sequence s_take;
		st_ff.hs == HS_IDLE && !commandStrobeN && st_ff.portEn;
	endsequence

	sequence s_read_go;
		st_ff.hs == HS_RD_WAIT && !outputEnableN;
	endsequence

	sequence s_exec_cmd(logic [DATA_W-1:0] c);
		execData && st_ff.cmd == c;
	endsequence

	a_take_ready: assert property (s_take |=> !ready ##1 !ready) // RULE15
		else $error("ready did not drop after strobe taken");
	a_ready_return: assert property (st_ff.hs == HS_WAIT_RELEASE && commandStrobeN && !st_ff.secured |=> ready) // RULE15
		else $error("ready not back after strobe released");
	a_read_drive: assert property (s_read_go |=> (!dataValidN && dataOe)[*1]) // RULE16
		else $error("read data not driven with valid low");
	a_read_release: assert property (st_ff.hs == HS_RD_DRIVE && outputEnableN |=> dataValidN && !dataOe) // RULE16
		else $error("bus not released after output enable high");
	a_gp_readback: assert property (s_read_go ##0 st_ff.cmd == CMD_READ_GENERAL_BITS |=> dataOut == $past(curBits)) // RULE5
		else $error("general bits read back wrong");
	a_version_out: assert property (s_read_go ##0 st_ff.cmd == CMD_GET_VERSION |=> dataOut == IF_VERSION) // RULE13
		else $error("version word wrong");
	a_gp_set: assert property (s_exec_cmd(CMD_SET_GENERAL_BITS) ##0 !eraseFire
		|=> curBits == ($past(curBits) | $past(st_ff.data))) // RULE1
		else $error("set general bits mismatch");
	a_gp_clear: assert property (s_exec_cmd(CMD_CLEAR_GENERAL_BITS) ##0 !eraseFire
		|=> curBits == ($past(curBits) & ~$past(st_ff.data))) // RULE2
		else $error("clear general bits mismatch");
	a_erase_wipe: assert property (s_exec_cmd(CMD_FULL_ERASE) |=> curBits == '0 && fullEraseReq) // RULE3
		else $error("full erase left general bits");
	a_secure_lock: assert property (securityActive |-> !ready ##1 !ready) // RULE6
		else $error("port answered while secured");
	a_select_ctrl: assert property (s_exec_cmd(CMD_SELECT_CONTROLLER) ##0 st_ff.data <= CTRL_MAX_SEL
		|=> currentCtrl == $past(st_ff.data[0])) // RULE10
		else $error("controller select not applied");
	a_mem_incr: assert property (s_exec_cmd(CMD_MEMORY_WRITE)
		|=> memWrEn && memWrAddr == $past(st_ff.addr) && st_ff.addr == $past(st_ff.addr) + ADDR_STEP) // RULE12
		else $error("memory write address not stepped");
	a_flush_entry: assert property (st_ff.hs == HS_EXEC && st_ff.mode == MODE_COMMAND_ENTRY |=> flushReq) // RULE14
		else $error("no flush on command entry");
	a_pin_unsecure: assert property (eraseFire |=> !securityActive && gpBits == '0) // RULE8
		else $error("pin erase did not clear security");
endmodule

// ===== sim/pfa_programmer.sv
// parallel programmer model: write and read handshakes on the port pins
// assumes device pins synchronous to mclk; levels sampled on the rising edge
`timescale 1ns/1ns
module pfa_programmer (
	input wire logic mclk,
	input wire logic ready,
	input wire logic dataValidN,
	input wire logic [pfa_pkg::DATA_W-1:0] busIn,
	output logic [pfa_pkg::MODE_W-1:0] modeOut,
	output logic [pfa_pkg::DATA_W-1:0] busOut,
	output logic commandStrobeN,
	output logic outputEnableN
);
	import pfa_pkg::*;
	initial begin
		modeOut = '0;
		busOut = '0;
		commandStrobeN = 1'b1;
		outputEnableN = 1'b1;
	end
	// bounded wait; a dead port leaves the caller to judge the pins
	task automatic waitFor(input bit useValid, input logic v);
		int n;
		for (n = 0; n < 64; n++) begin
			@(posedge mclk);
			if ((useValid ? dataValidN : ready) === v) break;
		end
	endtask
	// each step acts at the same rising edge that showed the answer
	task automatic wr(input logic [MODE_W-1:0] m, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		modeOut <= m;
		busOut <= d;
		commandStrobeN <= 1'b0;
		waitFor(1'b0, 1'b0);
		busOut <= ~d; // released lines hold no stale value
		commandStrobeN <= 1'b1;
		waitFor(1'b0, 1'b1);
	endtask
	task automatic rd(output logic [DATA_W-1:0] q);
		@(posedge mclk);
		modeOut <= MODE_DATA;
		busOut <= '0;
		commandStrobeN <= 1'b0;
		waitFor(1'b0, 1'b0);
		busOut <= 16'hffff;
		outputEnableN <= 1'b0;
		waitFor(1'b1, 1'b0);
		q = busIn;
		outputEnableN <= 1'b1;
		waitFor(1'b1, 1'b1);
		commandStrobeN <= 1'b1;
		waitFor(1'b0, 1'b1);
	endtask
endmodule

// ===== sim/tb_top.sv
// self-checking bench of the fast programming port sequencer
// assumes pfa_pkg and pfa_programmer compiled first
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
$display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_top;
	import pfa_pkg::*;
	localparam int ERASE_N = 20;
	logic mclk, rst_n, avRead, avWrite, dataOe, ready, dataValidN, erasePin, testSelectPin;
	logic commandStrobeN, outputEnableN, memWrEn, flushReq, fullEraseReq, eraseCtrlSel;
	logic currentCtrl, securityActive, avWaitrequest;
	logic [AV_ADDR_W-1:0] avAddress;
	logic [31:0] avWritedata, avReaddata, memWrAddr, rv, base;
	logic [MODE_W-1:0] modeIn;
	logic [DATA_W-1:0] dataOut, memWrData, progBus, q, d;
	logic [GP_W-1:0] gp [2];
	wire logic [DATA_W-1:0] bus = dataOe ? dataOut : progBus;
	logic [31:0] expA [$], expD [$], gotA [$], gotD [$];
	int failures, cmp_count, cyc, flushCnt, expFlush, eraseCnt, expErase, i, j, k, c;
	logic [DATA_W-1:0] ops [6] = '{CMD_SET_GENERAL_BITS, CMD_SET_GENERAL_BITS, CMD_CLEAR_GENERAL_BITS,
		CMD_SET_GENERAL_BITS, CMD_FULL_ERASE, CMD_CLEAR_GENERAL_BITS};
	logic [AV_ADDR_W-1:0] rA [5] = '{REG_CTRL, REG_STATUS, REG_GPBITS, REG_VERSION, 5'h14};
	logic [31:0] rE [5] = '{32'h1, 32'h0, 32'h0, {16'h0, IF_VERSION}, 32'h0};
	pfa_seq #(.ERASE_CYCLES(ERASE_N)) dut (.mclk(mclk), .rst_n(rst_n), .avAddress(avAddress),
		.avRead(avRead), .avWrite(avWrite), .avWritedata(avWritedata), .avReaddata(avReaddata),
		.avWaitrequest(avWaitrequest), .modeIn(modeIn), .dataIn(bus), .dataOut(dataOut), .dataOe(dataOe),
		.commandStrobeN(commandStrobeN), .outputEnableN(outputEnableN), .ready(ready),
		.dataValidN(dataValidN), .erasePin(erasePin), .testSelectPin(testSelectPin), .memWrEn(memWrEn),
		.memWrAddr(memWrAddr), .memWrData(memWrData), .flushReq(flushReq), .fullEraseReq(fullEraseReq),
		.eraseCtrlSel(eraseCtrlSel), .currentCtrl(currentCtrl), .securityActive(securityActive));
	pfa_programmer p (.mclk(mclk), .ready(ready), .dataValidN(dataValidN), .busIn(bus), .modeOut(modeIn),
		.busOut(progBus), .commandStrobeN(commandStrobeN), .outputEnableN(outputEnableN));
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////
	// pulses are registered, so the falling edge sees them settled
	always @(negedge mclk) begin
		if (memWrEn === 1'b1) begin
			gotA.push_back(memWrAddr);
			gotD.push_back({16'h0, memWrData});
		end
		if (flushReq === 1'b1) flushCnt++;
		if (fullEraseReq === 1'b1) eraseCnt++;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 30000) begin
			failures++;
			results();
		end
	end
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic av(input logic w, input logic [AV_ADDR_W-1:0] a, input logic [31:0] wd, output logic [31:0] r);
		@(posedge mclk);
		avAddress <= a;
		avWrite <= w;
		avRead <= !w;
		avWritedata <= wd;
		// only the cycle timeout ends a stuck wait
		do begin
			@(posedge mclk);
		end while (avWaitrequest !== 1'b0);
		r = avReaddata;
		avRead <= 1'b0;
		avWrite <= 1'b0;
	endtask
	task automatic cmd(input logic [DATA_W-1:0] cw, input logic [DATA_W-1:0] dw);
		p.wr(MODE_COMMAND_ENTRY, cw);
		expFlush++;
		if (cw != CMD_GET_VERSION && cw != CMD_READ_GENERAL_BITS && cw != CMD_MEMORY_WRITE) p.wr(MODE_DATA, dw);
	endtask
	function automatic logic [GP_W-1:0] expGp(input logic [GP_W-1:0] o, input logic [DATA_W-1:0] cw,
		input logic [GP_W-1:0] pat);
		if (cw == CMD_SET_GENERAL_BITS) return o | pat;
		if (cw == CMD_CLEAR_GENERAL_BITS) return o & ~pat;
		return '0;
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h5f3a74c3));
		{rst_n, avRead, avWrite, erasePin} = '0;
		testSelectPin = 1'b1;
		avAddress = '0;
		avWritedata = '0;
		gp = '{16'h0, 16'h0};
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		@(negedge mclk);
		`CHK("ready", 1'b1, ready)
		`CHK("ctrl", 1'b0, currentCtrl)
		for (i = 0; i < 5; i++) begin
			av(1'b0, rA[i], 32'h0, rv);
			`CHK("reg", rE[i], rv)
		end
		for (i = 0; i < 2; i++) begin
			av(1'b1, REG_CTRL, 32'(i), rv);
			av(1'b0, REG_CTRL, 32'h0, rv);
			`CHK("ctrl reg", 32'(i), rv)
		end
		cmd(CMD_GET_VERSION, 16'h0);
		p.rd(q);
		`CHK("version", IF_VERSION, q)
		for (i = 0; i < 6; i++) begin
			c = $urandom % 2;
			cmd(CMD_SELECT_CONTROLLER, 16'(c));
			@(negedge mclk);
			`CHK("select", c[0], currentCtrl)
			d = $urandom;
			cmd(ops[i], d);
			gp[c] = expGp(gp[c], ops[i], d);
			if (ops[i] == CMD_FULL_ERASE) begin
				expErase++;
				`CHK("erase ctrl", c[0], eraseCtrlSel)
			end
			cmd(CMD_READ_GENERAL_BITS, 16'h0);
			p.rd(q);
			`CHK("gp bits", gp[c], q)
			av(1'b0, REG_GPBITS, 32'h0, rv);
			`CHK("gp reg", {gp[1], gp[0]}, rv)
		end
		// bit 0 opposite to the current choice, so an accepted select shows
		cmd(CMD_SELECT_CONTROLLER, 16'h0002 | 16'(c == 0));
		`CHK("bad select", c[0], currentCtrl)
		cmd(CMD_MEMORY_WRITE, 16'h0);
		for (k = 0; k < 2; k++) begin
			base = $urandom;
			p.wr(MODE_LOW_ADDRESS, base[15:0]);
			p.wr(MODE_HIGH_ADDRESS, base[31:16]);
			for (j = 0; j < 3; j++) begin
				d = $urandom;
				p.wr(MODE_DATA, d);
				expA.push_back(base + 32'(j));
				expD.push_back({16'h0, d});
			end
		end
		av(1'b0, REG_ADDR, 32'h0, rv);
		`CHK("addr reg", base + 32'h3, rv)
		`CHK("writes", 32'(expA.size()), 32'(gotA.size()))
		while (expA.size() > 0 && gotA.size() > 0) begin
			`CHK("wr addr", expA.pop_front(), gotA.pop_front())
			`CHK("wr data", expD.pop_front(), gotD.pop_front())
		end
		cmd(CMD_SELECT_CONTROLLER, 16'h0001);
		cmd(CMD_SET_SECURITY, 16'h0);
		`CHK("secure ctrl1", 1'b0, securityActive)
		cmd(CMD_SELECT_CONTROLLER, 16'h0000);
		cmd(CMD_SET_SECURITY, 16'h0);
		`CHK("secure", 1'b1, securityActive)
		p.wr(MODE_COMMAND_ENTRY, CMD_GET_VERSION);
		`CHK("locked", 1'b0, ready)
		av(1'b0, REG_STATUS, 32'h0, rv);
		`CHK("status", (32'h1 << STAT_SECURED_BIT) | (32'h1 << STAT_BUSY_BIT), rv)
		@(posedge mclk);
		erasePin <= 1'b1;
		repeat (ERASE_N + 6) @(posedge mclk);
		`CHK("test high", 1'b1, securityActive)
		testSelectPin <= 1'b0;
		repeat (ERASE_N + 6) @(posedge mclk);
		erasePin <= 1'b0;
		expErase++;
		@(negedge mclk);
		`CHK("unsecure", 1'b0, securityActive)
		av(1'b0, REG_GPBITS, 32'h0, rv);
		`CHK("pin wipe", 32'h0, rv)
		`CHK("flushes", expFlush, flushCnt)
		`CHK("erases", expErase, eraseCnt)
		results();
	end
endmodule
